/* File: core/mon_entry_pkg.sv */
package mon_entry_pkg;
   localparam logic [15:0] RST_VEC_USER = 16'hfffe;
   localparam logic [15:0] SWI_VEC_USER = 16'hfffc;
   localparam logic [15:0] RST_VEC_MON = 16'hfefe;
   localparam logic [15:0] SWI_VEC_MON = 16'hfefc;
   localparam logic [7:0] BLANK_BYTE = 8'hff;
   localparam int BAUD_DIV = 278;
   localparam int SEC_BYTES = 8;
   localparam int BREAK_BITS = 10;
   localparam int DATA_BITS = 8;
   localparam int ECHO_GAP_BITS = 2;
   localparam int BUS_DIV_NORMAL_LOW = 2;
   localparam int BUS_DIV_NORMAL_HIGH = 4;
   localparam int BUS_DIV_FORCED = 4;
   localparam int EXTRA_RESET_CYCLES = 16;
endpackage

/* File: core/mon_entry_ctrl.sv */
`timescale 1ns/1ps
module mon_entry_ctrl #(
   parameter int BIT_CLKS = mon_entry_pkg::BAUD_DIV
) (
   input wire logic clk, // system clock, one bus cycle per edge
   input wire logic rst, // async reset, active high
   input wire logic reset_pin_n, // external reset pin level
   input wire logic irq_test_voltage, // test voltage seen on interrupt pin
   input wire logic rst_test_voltage, // test voltage seen on reset pin
   input wire logic rst_vec_blank, // reset vector reads as blank
   input wire logic secondary_serial_select_pin, // entry select level
   input wire logic mode_select_zero_pin, // entry select level
   input wire logic mode_select_one_pin, // entry select level
   input wire logic divider_select_pin, // divider select level
   input wire logic monitor_serial_in, // serial pin level
   output logic monitor_serial_out, // serial pin drive value (always 0)
   output logic monitor_serial_oe, // high while pulling serial pin low
   output logic monitor_mode, // monitor mode latched
   output logic forced_mode, // forced entry latched
   output logic [2:0] bus_div, // bus clock divide ratio of input
   output logic osc_bypass, // generator output equals crystal clock
   output logic watchdog_disable, // watchdog held off
   output logic extra_reset, // internal extra reset request
   output logic [15:0] reset_vector_addr, // reset vector fetch address
   output logic [15:0] swi_vector_addr, // swi and break vector address
   output logic security_done, // all security bytes received
   output logic [7:0] rx_data, // last received byte
   output logic rx_valid // one-cycle pulse per received byte
);
   // ***********************************************
   // entry capture
   // ***********************************************
   logic reset_pin_d_r;
   logic monitor_r, forced_r, div_hi_r, extra_done_r, extra_r;
   logic [4:0] extra_cnt_r;
   wire release_edge = reset_pin_n & ~reset_pin_d_r;
   wire pins_ok = ~secondary_serial_select_pin & mode_select_zero_pin &
                  ~mode_select_one_pin & monitor_serial_in;
   wire normal_req = irq_test_voltage & pins_ok;
   wire forced_req = ~irq_test_voltage & rst_vec_blank & monitor_serial_in
                     & ~secondary_serial_select_pin;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reset_pin_d_r <= 1'b0;
         monitor_r <= 1'b0;
         forced_r <= 1'b0;
         div_hi_r <= 1'b0;
      end else begin
         reset_pin_d_r <= reset_pin_n;
         if (release_edge) begin
            monitor_r <= normal_req | forced_req;
            forced_r <= forced_req;
            div_hi_r <= divider_select_pin & normal_req;
         end
      end
   end

   // extra reset once per power-up when entering with blank vector
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         extra_done_r <= 1'b0;
         extra_r <= 1'b0;
         extra_cnt_r <= 5'h00;
      end else if (extra_r) begin
         extra_cnt_r <= extra_cnt_r + 5'h01;
         if (extra_cnt_r == 5'(mon_entry_pkg::EXTRA_RESET_CYCLES - 1))
            extra_r <= 1'b0;
      end else if (release_edge && rst_vec_blank && !extra_done_r &&
                   (normal_req || forced_req)) begin
         extra_r <= 1'b1;
         extra_done_r <= 1'b1;
         extra_cnt_r <= 5'h00;
      end
   end
   assign extra_reset = extra_r;
   assign monitor_mode = monitor_r;
   assign forced_mode = forced_r;

   // ***********************************************
   // clocking, watchdog, vectors
   // ***********************************************
   assign bus_div = (forced_r || div_hi_r) ?
                    3'(mon_entry_pkg::BUS_DIV_NORMAL_HIGH) :
                    3'(mon_entry_pkg::BUS_DIV_NORMAL_LOW);
   assign osc_bypass = monitor_r & ~forced_r & ~div_hi_r;
   assign watchdog_disable = monitor_r &
      (forced_r | irq_test_voltage | rst_test_voltage);
   // full 16-bit vector addresses
   assign reset_vector_addr = monitor_r ? mon_entry_pkg::RST_VEC_MON :
                              mon_entry_pkg::RST_VEC_USER;
   assign swi_vector_addr = monitor_r ? mon_entry_pkg::SWI_VEC_MON :
                            mon_entry_pkg::SWI_VEC_USER;

   // ***********************************************
   // serial engine
   // ***********************************************
   typedef enum logic [2:0] {
      S_IDLE = 3'b000, S_RX = 3'b001, S_GAP = 3'b011,
      S_TX = 3'b010, S_BRK = 3'b110
   } ser_state_e;
   ser_state_e state_r, state_nxt;
   logic [8:0] bit_cnt_r;
   logic [3:0] bits_r;
   logic [7:0] sh_r, tx_r;
   logic [3:0] sec_cnt_r;
   logic drive_low_r, valid_r;
   wire bit_end = bit_cnt_r == 9'(BIT_CLKS - 1);
   wire mid_bit = bit_cnt_r == 9'(BIT_CLKS / 2);
   wire sec_last = sec_cnt_r == 4'(mon_entry_pkg::SEC_BYTES - 1);
   wire rx_last = bits_r == 4'(mon_entry_pkg::DATA_BITS);
   wire gap_last = bits_r == 4'(mon_entry_pkg::ECHO_GAP_BITS - 1);
   wire tx_last = bits_r == 4'(mon_entry_pkg::DATA_BITS + 1);
   wire brk_last = bits_r == 4'(mon_entry_pkg::BREAK_BITS - 1);

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         S_IDLE: if (monitor_r && !monitor_serial_in) state_nxt = S_RX;
         S_RX: if (bit_end && rx_last) state_nxt = S_GAP;
         S_GAP: if (bit_end && gap_last) state_nxt = S_TX;
         S_TX: if (bit_end && tx_last)
            state_nxt = (!security_done && sec_last) ? S_BRK : S_IDLE;
         S_BRK: if (bit_end && brk_last) state_nxt = S_IDLE;
         default: state_nxt = S_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= S_IDLE;
         bit_cnt_r <= 9'h000;
         bits_r <= 4'h0;
      end else begin
         state_r <= state_nxt;
         if (state_nxt != state_r || bit_end) bit_cnt_r <= 9'h000;
         else bit_cnt_r <= bit_cnt_r + 9'h001;
         if (state_nxt != state_r) bits_r <= 4'h0;
         else if (bit_end) bits_r <= bits_r + 4'h1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sh_r <= 8'h00;
         tx_r <= 8'h00;
         valid_r <= 1'b0;
         sec_cnt_r <= 4'h0;
         security_done <= 1'b0;
      end else begin
         valid_r <= 1'b0;
         // lsb first; the start bit sample is discarded
         if (state_r == S_RX && mid_bit && bits_r != 4'h0)
            sh_r <= {monitor_serial_in, sh_r[7:1]};
         if (state_r == S_RX && bit_end && rx_last) begin
            tx_r <= sh_r;
            valid_r <= 1'b1;
         end
         if (state_r == S_TX && bit_end && tx_last && !security_done) begin
            if (sec_last) security_done <= 1'b1;
            else sec_cnt_r <= sec_cnt_r + 4'h1;
         end
      end
   end
   assign rx_data = tx_r;
   assign rx_valid = valid_r;

   // bit slot that the echo will show after this edge: 0 start, 1..8 data
   wire [3:0] tx_bit_nxt = (state_r != S_TX) ? 4'h0 :
                           (bit_end ? bits_r + 4'h1 : bits_r);
   wire [3:0] tx_idx = tx_bit_nxt - 4'h1;
   wire tx_low = (tx_bit_nxt == 4'h0) ||
                 ((tx_bit_nxt <= 4'(mon_entry_pkg::DATA_BITS)) &&
                  !tx_r[tx_idx[2:0]]);

   // only ever pulls low; pullup supplies the high level
   always_ff @(posedge clk or posedge rst) begin
      if (rst) drive_low_r <= 1'b0;
      else case (state_nxt)
         S_TX: drive_low_r <= tx_low;
         S_BRK: drive_low_r <= 1'b1;
         default: drive_low_r <= 1'b0;
      endcase
   end
   assign monitor_serial_oe = drive_low_r;
   assign monitor_serial_out = 1'b0;

   // ***********************************************
   // checks
   // ***********************************************
   sequence s_entry;
      release_edge && normal_req;
   endsequence
   sequence s_forced_entry;
      release_edge && !irq_test_voltage && rst_vec_blank &&
      monitor_serial_in && !secondary_serial_select_pin;
   endsequence
   sequence s_blank_entry;
      release_edge && rst_vec_blank && (normal_req || forced_req) &&
      !extra_done_r && !extra_r;
   endsequence
   sequence s_gap_done;
      state_r == S_GAP && bit_end && gap_last;
   endsequence
   a_capture_mode: assert property (@(posedge clk) disable iff (rst)
      s_entry |=> monitor_mode)
      else $error("monitor mode not captured");
   a_mode_holds: assert property (@(posedge clk) disable iff (rst)
      !release_edge |=> $stable(monitor_mode))
      else $error("mode changed without reset edge");
   a_break_low: assert property (@(posedge clk) disable iff (rst)
      $rose(state_r == S_BRK) |-> ##1 monitor_serial_oe[*8])
      else $error("break not held low");
   a_done_break: assert property (@(posedge clk) disable iff (rst)
      $rose(security_done) |-> state_r == S_BRK)
      else $error("break not sent after security bytes");
   a_only_low: assert property (@(posedge clk) disable iff (rst)
      monitor_serial_out == 1'b0)
      else $error("serial pin driven high");
   a_idle_quiet: assert property (@(posedge clk) disable iff (rst)
      state_r == S_IDLE || state_r == S_RX || state_r == S_GAP
      |-> !monitor_serial_oe)
      else $error("serial pin pulled while listening");
   a_div_two: assert property (@(posedge clk) disable iff (rst)
      monitor_mode && !forced_mode && osc_bypass |->
      bus_div == 3'd2)
      else $error("wrong divide by two");
   a_div_four: assert property (@(posedge clk) disable iff (rst)
      monitor_mode && !forced_mode && !osc_bypass |->
      bus_div == 3'd4)
      else $error("wrong divide by four");
   a_bypass_only: assert property (@(posedge clk) disable iff (rst)
      osc_bypass |-> monitor_mode && !forced_mode)
      else $error("bypass outside normal entry");
   a_normal_wdog: assert property (@(posedge clk) disable iff (rst)
      monitor_mode && (irq_test_voltage || rst_test_voltage)
      |-> watchdog_disable)
      else $error("watchdog active under test voltage");
   a_user_wdog: assert property (@(posedge clk) disable iff (rst)
      !monitor_mode |-> !watchdog_disable)
      else $error("watchdog held off in user mode");
   a_forced_ignore: assert property (@(posedge clk) disable iff (rst)
      s_forced_entry |=> forced_mode && bus_div == 3'd4)
      else $error("forced entry used port b levels");
   a_extra_reset: assert property (@(posedge clk) disable iff (rst)
      s_blank_entry |=> extra_reset)
      else $error("no extra reset on blank vector");
   a_extra_len: assert property (@(posedge clk) disable iff (rst)
      $rose(extra_reset) |-> extra_reset[*8])
      else $error("extra reset too short");
   a_refuse_forced: assert property (@(posedge clk) disable iff (rst)
      release_edge && !irq_test_voltage && !rst_vec_blank
      |=> !monitor_mode)
      else $error("forced entry not refused");
   a_forced_div: assert property (@(posedge clk) disable iff (rst)
      forced_mode |-> bus_div == 3'd4 && !osc_bypass)
      else $error("forced divider wrong");
   a_forced_wdog: assert property (@(posedge clk) disable iff (rst)
      forced_mode |-> watchdog_disable)
      else $error("watchdog active in forced mode");
   a_vec_page: assert property (@(posedge clk) disable iff (rst)
      monitor_mode |-> reset_vector_addr[15:8] == 8'hfe)
      else $error("vector page wrong");
   a_swi_page: assert property (@(posedge clk) disable iff (rst)
      monitor_mode |-> swi_vector_addr == 16'hfefc)
      else $error("swi vector page wrong");
   a_user_vec: assert property (@(posedge clk) disable iff (rst)
      !monitor_mode |-> reset_vector_addr == 16'hfffe &&
      swi_vector_addr == 16'hfffc)
      else $error("user vectors wrong");
   a_bit_time: assert property (@(posedge clk) disable iff (rst)
      bit_cnt_r <= 9'(BIT_CLKS - 1))
      else $error("bit counter overran");
   a_echo_start: assert property (@(posedge clk) disable iff (rst)
      s_gap_done |=> monitor_serial_oe)
      else $error("echo start bit missing");
endmodule

/* File: dv/host_model.sv */
`timescale 1ns/1ps
// ****
// host end of the serial wire
// ****
module host_model #(
   parameter int BIT_CLKS = 16
) (
   input wire logic clk, // bench clock
   input wire logic line, // resolved serial wire
   output logic host_oe // high pulls the wire low
);
   initial host_oe = 1'b0;
   // never drives high, the pullup makes ones
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         host_oe <= ~f[i];
         repeat (BIT_CLKS) @(posedge clk);
      end
   endtask
   // bounded hunt for a start bit, then mid-bit samples, lsb first
   task automatic recv_byte(output logic [7:0] b, output bit ok);
      int n;
      n = 0;
      b = 8'h00;
      while (line !== 1'b0 && n < 100 * BIT_CLKS) begin
         @(posedge clk);
         n++;
      end
      ok = n < 100 * BIT_CLKS;
      repeat (BIT_CLKS / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CLKS) @(posedge clk);
         b[i] = line;
      end
      repeat (BIT_CLKS) @(posedge clk);
   endtask
endmodule

/* File: dv/test_monitor_mode_entry_control.sv */
`timescale 1ns/1ps
// ****
// entry, clocking, vectors, echo and break
// ****
module test_monitor_mode_entry_control;
   localparam int B = 16;
   logic clk = 1'b0, rst = 1'b1, reset_pin_n = 1'b0, irq_test_voltage = 1'b0;
   logic rst_test_voltage = 1'b0, rst_vec_blank = 1'b0, divider_select_pin = 1'b0;
   logic secondary_serial_select_pin = 1'b0, mode_select_zero_pin = 1'b0;
   logic mode_select_one_pin = 1'b0;
   logic host_oe, oe, mon, frc, byp, wdd, xrst, sdone, rxv, xseen, sout;
   logic [2:0] bdiv;
   logic [15:0] rva, sva;
   logic [7:0] rxd, last_rx, b, e;
   bit ok;
   int failures = 0, n_tests = 0, seed = 32'h3f19ac6a, c;
   wire line = ~(oe | host_oe); // pullup when nobody pulls
   always #25 clk = ~clk;
   always @(posedge clk) if (rxv === 1'b1) last_rx <= rxd;
   mon_entry_ctrl #(.BIT_CLKS(B)) uut (.clk, .rst, .reset_pin_n,
      .irq_test_voltage, .rst_test_voltage, .rst_vec_blank,
      .secondary_serial_select_pin, .mode_select_zero_pin,
      .mode_select_one_pin, .divider_select_pin, .monitor_serial_in(line),
      .monitor_serial_out(sout), .monitor_serial_oe(oe), .monitor_mode(mon),
      .forced_mode(frc), .bus_div(bdiv), .osc_bypass(byp),
      .watchdog_disable(wdd), .extra_reset(xrst), .reset_vector_addr(rva),
      .swi_vector_addr(sva), .security_done(sdone), .rx_data(rxd),
      .rx_valid(rxv));
   host_model #(.BIT_CLKS(B)) host (.clk, .line, .host_oe);
   function automatic logic [2:0] exp_div(input logic nrm, input logic d);
      return (nrm && !d) ? 3'h2 : 3'h4;
   endfunction
   task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
      n_tests++;
      if (g !== x) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, x, g);
      end
   endtask
   // pins: irq, rst voltage, blank, sec_sel, mode0, mode1, divider
   task automatic enter(input logic [6:0] p);
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      {irq_test_voltage, rst_test_voltage, rst_vec_blank,
         secondary_serial_select_pin, mode_select_zero_pin,
         mode_select_one_pin, divider_select_pin} <= p;
      reset_pin_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_pin_n <= 1'b1;
      xseen = 1'b0;
      repeat (4) begin
         @(posedge clk);
         #1 xseen = xseen | (xrst === 1'b1);
      end
   endtask
   task automatic look(input logic m, f, nrm, d);
      chk("monitor_mode", m, mon);
      chk("forced_mode", f, frc);
      chk("serial_out", 0, sout);
      chk("watchdog_disable", m, wdd);
      chk("reset_vector", m ? 16'hfefe : 16'hfffe, rva);
      chk("swi_vector", m ? 16'hfefc : 16'hfffc, sva);
      if (m) begin
         chk("bus_div", exp_div(nrm, d), bdiv);
         chk("osc_bypass", nrm & ~d, byp);
      end
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      #(20000 * 50);
      failures++;
      close_out;
   end
   initial begin
      repeat (5) @(posedge clk);
      enter(7'b1000100);
      look(1, 0, 1, 0);
      chk("extra_reset", 0, xseen);
      @(posedge clk);
      {secondary_serial_select_pin, mode_select_zero_pin, mode_select_one_pin,
         divider_select_pin} <= 4'($random(seed));
      repeat (3) @(posedge clk);
      #1 look(1, 0, 1, 0);
      @(posedge clk);
      rst_test_voltage <= 1'b1;
      @(posedge clk);
      irq_test_voltage <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk("watchdog_disable", 1, wdd);
      @(posedge clk);
      rst_test_voltage <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk("watchdog_disable", 0, wdd);
      @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         b = (i == 7) ? 8'h00 : 8'($random(seed));
         chk("security_done", 0, sdone);
         host.send_byte(b);
         host.recv_byte(e, ok);
         chk("echo", {ok, b}, {ok, e});
         chk("rx_data", b, last_rx);
         repeat (B) @(posedge clk);
      end
      c = 0;
      while (line !== 1'b0 && c < 100 * B) begin
         @(posedge clk);
         c++;
      end
      c = 0;
      while (line === 1'b0 && c < 100 * B) begin
         @(posedge clk);
         c++;
      end
      chk("break_bits", 10, (c + B / 2) / B);
      chk("security_done", 1, sdone);
      $display("test normal entry done");
      enter(7'b1000101);
      look(1, 0, 1, 1);
      b = 8'($random(seed));
      enter({4'b0010, b[2:0]});
      look(1, 1, 0, b[0]);
      chk("extra_reset", 1, xseen);
      @(posedge clk);
      {irq_test_voltage, rst_test_voltage} <= 2'b11;
      repeat (2) @(posedge clk);
      #1 look(1, 1, 0, b[1]);
      chk("watchdog_disable", 1, wdd);
      $display("test forced entry done");
      enter({4'b0000, b[5:3]});
      look(0, 0, 0, 0);
      $display("test refused entry done");
      close_out;
   end
endmodule
